// ---- design/astc_params.svh ----
// Constants for the ADC sequence and trigger controller
//
// Behaviour
// - Regular split mode converts subsequences of n.
// - Each trigger converts the next regular subsequence.
// - Regular done only after final subsequence.
// - After last subsequence, next trigger restarts.
// - Injected split converts one channel per trigger.
// - Last injected split channel raises both dones.
// - Injected trigger has priority, preempts regular.
// - Preempted regular conversion resumes after injection.
// - No preemption in split or auto mode; injected trigger ignored.
// - Auto injection follows regular group directly.
// - Auto plus continuous repeats combined sequence.
// - Stop aborts, discards result, resets, idles.
// - Stop completion clears stop and regular soft start.
// - Window flag on result outside thresholds.
// - Window compares raw result before alignment.
// - Guard selection by group enables, single bit.
// - Rising edge of selected source starts group.
// - Regular select encoding of eight sources.
// - Injected select encoding of eight sources.
// - Regular done stores result, sets done flag.
`ifndef ASTC_PARAMS_SVH
`define ASTC_PARAMS_SVH

`define ASTC_RES_W     12
`define ASTC_DATA_W    16
`define ASTC_PAD_W     4
`define ASTC_POS_W     4
`define ASTC_SUB_W     3
`define ASTC_INJ_W     2
`define ASTC_CH_W      5
`define ASTC_SEL_W     3
`define ASTC_NSRC      8
`define ASTC_POS_RST   4'h0
`define ASTC_SUB_RST   3'h0
`define ASTC_INJ_RST   2'h0
`define ASTC_DATA_RST  16'h0000
`define ASTC_POS_STEP  4'h1
`define ASTC_SUB_STEP  3'h1
`define ASTC_INJ_STEP  2'h1
`define ASTC_PAD_VAL   4'h0

`endif

// ---- design/astc_pkg.sv ----
// Types for the ADC sequence and trigger controller
`include "astc_params.svh"
package astc_pkg;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_REG  = 4'b0010,
      ST_INJ  = 4'b0100,
      ST_STOP = 4'b1000
   } astc_state_e;

   typedef struct packed {
      logic                     converter_enable;
      logic                     scan_enable;
      logic                     continuous_enable;
      logic                     regular_split_enable;
      logic [`ASTC_SUB_W-1:0]   split_group_count;
      logic [`ASTC_POS_W-1:0]   regular_length;
      logic                     injected_split_enable;
      logic [`ASTC_INJ_W-1:0]   injected_sequence_length;
      logic                     auto_injection_enable;
      logic                     regular_trigger_enable;
      logic [`ASTC_SEL_W-1:0]   regular_trigger_select;
      logic                     injected_trigger_enable;
      logic [`ASTC_SEL_W-1:0]   injected_trigger_select;
      logic                     regular_guard_enable;
      logic                     injected_guard_enable;
      logic                     single_channel_guard;
      logic [`ASTC_CH_W-1:0]    guard_channel;
      logic [`ASTC_RES_W-1:0]   high_threshold;
      logic [`ASTC_RES_W-1:0]   low_threshold;
      logic                     window_guard_irq_enable;
      logic                     regular_done_irq_enable;
   } astc_cfg_s;

   typedef struct packed {
      logic timer1_ch1;
      logic timer1_ch2;
      logic timer1_ch3;
      logic timer1_ch4;
      logic timer1_trigger_output;
      logic timer2_trigger_output;
      logic timer2_ch1;
      logic timer3_trigger_output;
      logic timer3_ch4;
      logic timer15_trigger_output;
      logic external_interrupt_line11;
      logic external_interrupt_line15;
   } astc_trig_s;

   typedef struct packed {
      logic                   start;
      logic                   abort;
      logic                   injected;
      logic [`ASTC_POS_W-1:0] rank;
   } astc_core_req_s;

   typedef struct packed {
      logic                   done;
      logic [`ASTC_CH_W-1:0]  channel;
      logic [`ASTC_RES_W-1:0] result;
   } astc_core_rsp_s;

endpackage : astc_pkg

// ---- design/astc_sequencer.sv ----
// Conversion sequencer, trigger selection and window guard
`timescale 1ns/100ps
`default_nettype none
`include "astc_params.svh"
module astc_sequencer (
   // Clock and reset
   input  wire logic                      clk,
   input  wire logic                      rst_n,
   // Configuration bits
   input  wire astc_pkg::astc_cfg_s       cfg,
   // Hardware trigger sources
   input  wire astc_pkg::astc_trig_s      trig,
   // Software strobes
   input  wire logic                      regular_soft_start_set,
   input  wire logic                      injected_soft_start_set,
   input  wire logic                      conversion_stop_set,
   input  wire logic                      regular_done_clear,
   input  wire logic                      injected_done_clear,
   input  wire logic                      window_guard_clear,
   // Converter core
   output var  astc_pkg::astc_core_req_s  core_req,
   input  wire astc_pkg::astc_core_rsp_s  core_rsp,
   // Status
   output logic                           regular_soft_start,
   output logic                           injected_soft_start,
   output logic                           conversion_stop,
   output logic                           regular_done_flag,
   output logic                           injected_done_flag,
   output logic                           window_guard_flag,
   output logic                           regular_done_irq,
   output logic                           window_guard_irq,
   output logic [`ASTC_DATA_W-1:0]        regular_result
);

   astc_pkg::astc_state_e    state_ff, nxt_state;
   astc_pkg::astc_core_req_s req_ff, nxt_req;
   logic [`ASTC_POS_W-1:0]   reg_pos_ff, nxt_reg_pos;
   logic [`ASTC_SUB_W-1:0]   sub_ff, nxt_sub;
   logic [`ASTC_INJ_W-1:0]   inj_pos_ff, nxt_inj_pos;
   logic                     resume_ff, nxt_resume;
   logic                     reg_soft_ff, nxt_reg_soft;
   logic                     inj_soft_ff, nxt_inj_soft;
   logic                     stop_ff, nxt_stop;
   logic                     reg_prev_ff, nxt_reg_prev;
   logic                     inj_prev_ff, nxt_inj_prev;
   logic [`ASTC_DATA_W-1:0]  result_ff, nxt_result;
   logic                     reg_done_ff, nxt_reg_done;
   logic                     inj_done_ff, nxt_inj_done;
   logic                     guard_ff, nxt_guard;
   logic                     reg_irq_ff, nxt_reg_irq;
   logic                     guard_irq_ff, nxt_guard_irq;
   logic                     ev_reg_done, ev_inj_done, ev_conv;
   logic                     reg_trig, inj_trig, run_ok;
   logic [`ASTC_NSRC-1:0]    reg_src_vec, inj_src_vec;
   logic [`ASTC_POS_W-1:0]   reg_end;
   logic                     guarded, out_of_window;

   // Builds a one-cycle start request for the core
   function automatic astc_pkg::astc_core_req_s launch(
      input logic                   injected,
      input logic [`ASTC_POS_W-1:0] rank
   );
      astc_pkg::astc_core_req_s r;
      r.start    = 1'b1;
      r.abort    = 1'b0;
      r.injected = injected;
      r.rank     = rank;
      return r;
   endfunction : launch

   // Source vectors indexed by the select codes
   assign reg_src_vec = {reg_soft_ff, trig.external_interrupt_line11,
                         trig.timer15_trigger_output,
                         trig.timer3_trigger_output,
                         trig.timer2_trigger_output,
                         trig.timer1_ch3, trig.timer1_ch2,
                         trig.timer1_ch1};
   assign inj_src_vec = {inj_soft_ff, trig.external_interrupt_line15,
                         trig.timer15_trigger_output, trig.timer3_ch4,
                         trig.timer2_ch1, trig.timer2_trigger_output,
                         trig.timer1_ch4,
                         trig.timer1_trigger_output};

   // Rising edges only; a held level never retriggers
   assign reg_trig = cfg.regular_trigger_enable & ~reg_prev_ff &
                     reg_src_vec[cfg.regular_trigger_select];
   assign inj_trig = cfg.injected_trigger_enable & ~inj_prev_ff &
                     inj_src_vec[cfg.injected_trigger_select];
   assign run_ok   = cfg.converter_enable & ~stop_ff;
   // Without scan or split only the first rank is used
   assign reg_end  = (cfg.scan_enable | cfg.regular_split_enable) ?
                     cfg.regular_length : `ASTC_POS_RST;

   // Sequencer next state
   always_comb begin
      nxt_state    = state_ff;
      nxt_req      = req_ff;
      nxt_req.start = 1'b0;
      nxt_req.abort = 1'b0;
      nxt_reg_pos  = reg_pos_ff;
      nxt_sub      = sub_ff;
      nxt_inj_pos  = inj_pos_ff;
      nxt_resume   = resume_ff;
      nxt_reg_soft = reg_soft_ff | regular_soft_start_set;
      nxt_inj_soft = inj_soft_ff | injected_soft_start_set;
      nxt_stop     = stop_ff | conversion_stop_set;
      nxt_reg_prev = reg_src_vec[cfg.regular_trigger_select];
      nxt_inj_prev = inj_src_vec[cfg.injected_trigger_select];
      nxt_result   = result_ff;
      ev_reg_done  = 1'b0;
      ev_inj_done  = 1'b0;
      ev_conv      = 1'b0;
      if (state_ff == astc_pkg::ST_STOP) begin
         // Stop finished: release the bits and rewind
         nxt_stop     = conversion_stop_set;
         nxt_reg_soft = 1'b0;
         nxt_reg_pos  = `ASTC_POS_RST;
         nxt_sub      = `ASTC_SUB_RST;
         nxt_inj_pos  = `ASTC_INJ_RST;
         nxt_resume   = 1'b0;
         nxt_state    = astc_pkg::ST_IDLE;
      end else if (!run_ok) begin
         // Abort drops any pending done; result stays
         nxt_req.abort = (state_ff != astc_pkg::ST_IDLE);
         nxt_reg_pos  = `ASTC_POS_RST;
         nxt_sub      = `ASTC_SUB_RST;
         nxt_inj_pos  = `ASTC_INJ_RST;
         nxt_resume   = 1'b0;
         nxt_state    = stop_ff ? astc_pkg::ST_STOP : astc_pkg::ST_IDLE;
      end else begin
         case (state_ff)
            astc_pkg::ST_IDLE: begin
               if (inj_trig) begin
                  nxt_inj_soft = 1'b0;
                  nxt_req      = launch(1'b1, {2'b00, inj_pos_ff});
                  nxt_resume   = 1'b0;
                  nxt_state    = astc_pkg::ST_INJ;
               end else if (reg_trig) begin
                  nxt_reg_soft = 1'b0;
                  nxt_req      = launch(1'b0, reg_pos_ff);
                  nxt_sub      = `ASTC_SUB_RST;
                  nxt_state    = astc_pkg::ST_REG;
               end
            end
            astc_pkg::ST_REG: begin
               if (inj_trig && !cfg.regular_split_enable &&
                   !cfg.injected_split_enable &&
                   !cfg.auto_injection_enable) begin
                  // Preempt: kill regular, run injected, come back
                  nxt_inj_soft  = 1'b0;
                  nxt_req       = launch(1'b1, `ASTC_POS_RST);
                  nxt_req.abort = 1'b1;
                  nxt_inj_pos   = `ASTC_INJ_RST;
                  nxt_resume    = 1'b1;
                  nxt_state     = astc_pkg::ST_INJ;
               end else if (core_rsp.done) begin
                  ev_conv    = 1'b1;
                  nxt_result = {`ASTC_PAD_VAL, core_rsp.result};
                  if (reg_pos_ff == reg_end) begin
                     ev_reg_done = 1'b1;
                     nxt_reg_pos = `ASTC_POS_RST;
                     nxt_sub     = `ASTC_SUB_RST;
                     if (cfg.auto_injection_enable) begin
                        nxt_req     = launch(1'b1, `ASTC_POS_RST);
                        nxt_inj_pos = `ASTC_INJ_RST;
                        nxt_resume  = 1'b0;
                        nxt_state   = astc_pkg::ST_INJ;
                     end else if (cfg.continuous_enable &&
                                  !cfg.regular_split_enable) begin
                        nxt_req = launch(1'b0, `ASTC_POS_RST);
                     end else begin
                        nxt_state = astc_pkg::ST_IDLE;
                     end
                  end else begin
                     nxt_reg_pos = reg_pos_ff + `ASTC_POS_STEP;
                     if (cfg.regular_split_enable &&
                         sub_ff == cfg.split_group_count) begin
                        nxt_sub   = `ASTC_SUB_RST;
                        nxt_state = astc_pkg::ST_IDLE;
                     end else begin
                        nxt_sub = sub_ff + `ASTC_SUB_STEP;
                        nxt_req = launch(1'b0, nxt_reg_pos);
                     end
                  end
               end
            end
            astc_pkg::ST_INJ: begin
               // Regular triggers are not looked at here
               if (core_rsp.done) begin
                  ev_conv = 1'b1;
                  if (inj_pos_ff == cfg.injected_sequence_length) begin
                     ev_inj_done = 1'b1;
                     ev_reg_done = cfg.injected_split_enable;
                     nxt_inj_pos = `ASTC_INJ_RST;
                  end else begin
                     nxt_inj_pos = inj_pos_ff + `ASTC_INJ_STEP;
                  end
                  if (!ev_inj_done && !cfg.injected_split_enable) begin
                     nxt_req = launch(1'b1, {2'b00, nxt_inj_pos});
                  end else if (resume_ff) begin
                     nxt_req    = launch(1'b0, reg_pos_ff);
                     nxt_resume = 1'b0;
                     nxt_state  = astc_pkg::ST_REG;
                  end else if (ev_inj_done && cfg.auto_injection_enable &&
                               cfg.continuous_enable) begin
                     nxt_req   = launch(1'b0, `ASTC_POS_RST);
                     nxt_state = astc_pkg::ST_REG;
                  end else begin
                     nxt_state = astc_pkg::ST_IDLE;
                  end
               end
            end
            default: nxt_state = astc_pkg::ST_IDLE;
         endcase
      end
   end

   // Sequencer registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_ff    <= astc_pkg::ST_IDLE;
         req_ff      <= '0;
         reg_pos_ff  <= `ASTC_POS_RST;
         sub_ff      <= `ASTC_SUB_RST;
         inj_pos_ff  <= `ASTC_INJ_RST;
         resume_ff   <= 1'b0;
         reg_soft_ff <= 1'b0;
         inj_soft_ff <= 1'b0;
         stop_ff     <= 1'b0;
         reg_prev_ff <= 1'b0;
         inj_prev_ff <= 1'b0;
         result_ff   <= `ASTC_DATA_RST;
      end else begin
         state_ff    <= nxt_state;
         req_ff      <= nxt_req;
         reg_pos_ff  <= nxt_reg_pos;
         sub_ff      <= nxt_sub;
         inj_pos_ff  <= nxt_inj_pos;
         resume_ff   <= nxt_resume;
         reg_soft_ff <= nxt_reg_soft;
         inj_soft_ff <= nxt_inj_soft;
         stop_ff     <= nxt_stop;
         reg_prev_ff <= nxt_reg_prev;
         inj_prev_ff <= nxt_inj_prev;
         result_ff   <= nxt_result;
      end
   end

   // Guard on the raw core result, alignment never enters
   assign guarded = ((!req_ff.injected & cfg.regular_guard_enable) |
                     (req_ff.injected & cfg.injected_guard_enable)) &
                    (!cfg.single_channel_guard |
                     core_rsp.channel == cfg.guard_channel);
   assign out_of_window = (core_rsp.result < cfg.low_threshold) |
                          (core_rsp.result > cfg.high_threshold);

   // Sticky flags; a set in the clear cycle wins
   always_comb begin
      nxt_reg_done  = (reg_done_ff & ~regular_done_clear) | ev_reg_done;
      nxt_inj_done  = (inj_done_ff & ~injected_done_clear) | ev_inj_done;
      nxt_guard     = (guard_ff & ~window_guard_clear) |
                      (ev_conv & guarded & out_of_window);
      nxt_reg_irq   = nxt_reg_done & cfg.regular_done_irq_enable;
      nxt_guard_irq = nxt_guard & cfg.window_guard_irq_enable;
   end

   // Flag registers
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         reg_done_ff  <= 1'b0;
         inj_done_ff  <= 1'b0;
         guard_ff     <= 1'b0;
         reg_irq_ff   <= 1'b0;
         guard_irq_ff <= 1'b0;
      end else begin
         reg_done_ff  <= nxt_reg_done;
         inj_done_ff  <= nxt_inj_done;
         guard_ff     <= nxt_guard;
         reg_irq_ff   <= nxt_reg_irq;
         guard_irq_ff <= nxt_guard_irq;
      end
   end

   // Outputs straight from registers
   assign core_req            = req_ff;
   assign regular_soft_start  = reg_soft_ff;
   assign injected_soft_start = inj_soft_ff;
   assign conversion_stop     = stop_ff;
   assign regular_done_flag   = reg_done_ff;
   assign injected_done_flag  = inj_done_ff;
   assign window_guard_flag   = guard_ff;
   assign regular_done_irq    = reg_irq_ff;
   assign window_guard_irq    = guard_irq_ff;
   assign regular_result      = result_ff;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_stop_rewind: assert property (state_ff == astc_pkg::ST_STOP |=>
      state_ff == astc_pkg::ST_IDLE && reg_pos_ff == 4'h0 &&
      inj_pos_ff == 2'h0) else $error("stop did not rewind");
   a_stop_release: assert property (state_ff == astc_pkg::ST_STOP &&
      !conversion_stop_set |=> !stop_ff && !reg_soft_ff)
      else $error("stop bits not cleared");
   a_stop_result: assert property (stop_ff |=> $stable(result_ff))
      else $error("result changed during stop");
   a_split_quiet: assert property (state_ff == astc_pkg::ST_REG &&
      core_rsp.done && run_ok && cfg.regular_split_enable && !inj_trig &&
      reg_pos_ff != cfg.regular_length |-> !ev_reg_done)
      else $error("early regular done in split");
   a_split_pause: assert property (state_ff == astc_pkg::ST_REG &&
      core_rsp.done && run_ok && cfg.regular_split_enable && !inj_trig &&
      sub_ff == cfg.split_group_count && reg_pos_ff != cfg.regular_length
      |=> state_ff == astc_pkg::ST_IDLE && !req_ff.start)
      else $error("split subsequence did not pause");
   a_split_wrap: assert property (state_ff == astc_pkg::ST_REG &&
      core_rsp.done && run_ok && cfg.regular_split_enable && !inj_trig &&
      !cfg.auto_injection_enable && reg_pos_ff == cfg.regular_length
      |=> state_ff == astc_pkg::ST_IDLE && reg_pos_ff == 4'h0)
      else $error("split sequence did not wrap");
   a_inj_both: assert property (state_ff == astc_pkg::ST_INJ &&
      core_rsp.done && run_ok && cfg.injected_split_enable &&
      inj_pos_ff == cfg.injected_sequence_length
      |=> reg_done_ff && inj_done_ff) else $error("missing split dones");
   a_inj_preempt: assert property (state_ff == astc_pkg::ST_REG &&
      inj_trig && run_ok && !cfg.regular_split_enable &&
      !cfg.injected_split_enable && !cfg.auto_injection_enable
      |=> state_ff == astc_pkg::ST_INJ && req_ff.abort && req_ff.start &&
      req_ff.injected && resume_ff) else $error("no preemption");
   a_inj_hold: assert property (state_ff == astc_pkg::ST_INJ &&
      !core_rsp.done && run_ok |=> state_ff == astc_pkg::ST_INJ)
      else $error("injection left early");
   a_guard_hit: assert property (ev_conv && guarded &&
      out_of_window |=> guard_ff) else $error("window flag missed");
   a_result_store: assert property (state_ff == astc_pkg::ST_REG &&
      core_rsp.done && run_ok && !nxt_req.abort |=>
      result_ff == {4'h0, $past(core_rsp.result)} &&
      ($past(reg_pos_ff) != $past(reg_end) || reg_done_ff))
      else $error("regular result not stored");

   c_split_pause: cover property (state_ff == astc_pkg::ST_REG &&
      cfg.regular_split_enable ##1 state_ff == astc_pkg::ST_IDLE);
   c_preempt: cover property (req_ff.abort && req_ff.injected);
   c_stop: cover property (state_ff == astc_pkg::ST_STOP);
   c_auto_loop: cover property (state_ff == astc_pkg::ST_INJ ##1
      state_ff == astc_pkg::ST_REG && !resume_ff);

endmodule : astc_sequencer
`default_nettype wire

// ---- verif/astc_core_model.sv ----
// Converter core model answering each start after a set latency
`timescale 1ns/100ps
`default_nettype none
module astc_core_model (
   // Clock, reset and latency in cycles
   input  wire logic                     clk,
   input  wire logic                     rst_n,
   input  wire logic [3:0]               lat,
   // Raw result seed, rank steps are added
   input  wire logic [11:0]              base,
   // Sequencer side
   input  wire astc_pkg::astc_core_req_s req,
   output var  astc_pkg::astc_core_rsp_s rsp
);
   int cnt;
   // Abort drops the pending answer; result lines toggle while not valid
   always @(posedge clk) begin
      rsp.done <= 1'b0;
      rsp.result <= ~rsp.result;
      if (!rst_n || (req.abort && !req.start)) begin
         cnt <= 0;
         rsp.result <= 12'h5a5;
      end else if (req.start) begin
         cnt <= int'(lat);
         rsp.channel <= 5'(req.rank);
      end else if (cnt == 1) begin
         rsp.done <= 1'b1;
         rsp.result <= base + 12'h111 * 12'(req.rank);
         cnt <= 0;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule : astc_core_model
`default_nettype wire

// ---- verif/adc_sequence_trigger_control_bench.sv ----
// Random bench for the conversion sequencer
`timescale 1ns/100ps
`default_nettype none
module adc_sequence_trigger_control_bench;
   logic clk = 0, rst_n = 0, rs = 0, is = 0, sp = 0, rc = 0, ic = 0, wc = 0;
   logic rss, iss, stp, rdf, idf, wgf, rdi, wgi;
   logic [15:0] res, r0;
   logic [11:0] base = 12'h0a5;
   logic [3:0] lat = 4'h3, lrk;
   astc_pkg::astc_cfg_s cfg = '0;
   astc_pkg::astc_trig_s trig = '0;
   astc_pkg::astc_core_req_s req;
   astc_pkg::astc_core_rsp_s rsp;
   int error_cnt, n_checks, ns, nd, nab, n0, s0, a0, len, n, pos, e;
   int rmap[7] = '{11, 10, 9, 6, 4, 2, 1};
   int imap[7] = '{7, 8, 6, 5, 3, 2, 0};
   astc_sequencer uut (.clk(clk), .rst_n(rst_n), .cfg(cfg), .trig(trig),
      .regular_soft_start_set(rs), .injected_soft_start_set(is),
      .conversion_stop_set(sp), .regular_done_clear(rc),
      .injected_done_clear(ic), .window_guard_clear(wc), .core_req(req),
      .core_rsp(rsp), .regular_soft_start(rss), .injected_soft_start(iss),
      .conversion_stop(stp), .regular_done_flag(rdf),
      .injected_done_flag(idf), .window_guard_flag(wgf),
      .regular_done_irq(rdi), .window_guard_irq(wgi), .regular_result(res));
   astc_core_model core (.clk(clk), .rst_n(rst_n), .lat(lat), .base(base),
      .req(req), .rsp(rsp));
   initial forever #5 clk = ~clk;
   // Tally core traffic; rank kept for restart checks
   always @(posedge clk) begin
      if (req.start) ns <= ns + 1;
      if (req.start) lrk <= req.rank;
      if (req.abort) nab <= nab + 1;
      if (rsp.done) nd <= nd + 1;
   end
   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected bit at %0t: %h vs %h", $time, got, exp);
      end
   endtask : chk_bit
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected word at %0t: %h vs %h", $time, got, exp);
      end
   endtask : chk_word
   task automatic cyc(input int k);
      repeat (k) @(negedge clk);
   endtask : cyc
   task automatic strobe(ref logic s);
      s = 1'b1;
      cyc(1);
      s = 1'b0;
   endtask : strobe
   // Rising then falling edge; the falling one must start nothing
   task automatic fire(input logic inj, input int k);
      if (k == 7 && inj) strobe(is);
      else if (k == 7) strobe(rs);
      else begin
         trig[inj ? imap[k] : rmap[k]] = 1'b1;
         cyc(2);
         trig = '0;
      end
   endtask : fire
   // Bounded wait for the answer count, then let flags land
   task automatic settle(input int want);
      for (int i = 0; i < 400 && nd < want; i++) cyc(1);
      cyc(4);
   endtask : settle
   function automatic logic wd_exp(input logic [11:0] v);
      return cfg.regular_guard_enable && (!cfg.single_channel_guard ||
         cfg.guard_channel == 5'h00) &&
         (v < cfg.low_threshold || v > cfg.high_threshold);
   endfunction : wd_exp
   task automatic summarize;
      if (error_cnt == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : summarize
   initial begin
      #300000;
      error_cnt++;
      summarize();
   end
   initial begin
      void'($urandom(47));
      cfg.converter_enable = 1'b1;
      cfg.regular_trigger_enable = 1'b1;
      cfg.injected_trigger_enable = 1'b1; // Auto injection stays off
      cyc(6);
      rst_n = 1'b1;
      lat = 4'($urandom_range(9, 2));
      // Every select code of both groups, one conversion each
      for (int g = 0; g < 2; g++) for (int k = 0; k < 8; k++) begin
         cfg.regular_trigger_select = 3'(k);
         cfg.injected_trigger_select = 3'(k);
         cfg.injected_trigger_enable = 1'(g); // Code 5 shares a source
         n0 = nd;
         fire(g[0], k);
         settle(n0 + 1);
         chk_word(16'(nd - n0), 16'h0001);
         chk_bit(g ? idf : rdf, 1'b1);
         if (g == 0) chk_word(res, {4'h0, base});
         strobe(rc);
         strobe(ic);
      end
      // Regular split; no auto injection alongside
      cfg.scan_enable = 1'b1;
      cfg.injected_trigger_enable = 1'b1;
      cfg.regular_split_enable = 1'b1;
      cfg.split_group_count = 3'($urandom_range(2));
      n = int'(cfg.split_group_count) + 1;
      len = $urandom_range(7, 3);
      cfg.regular_length = 4'(len);
      pos = 0;
      repeat (10) begin
         n0 = nd;
         e = (len + 1 - pos < n) ? len + 1 - pos : n;
         fire(1'b0, 7);
         settle(n0 + e);
         chk_word(16'(nd - n0), 16'(e));
         chk_word(16'(lrk), 16'(pos + e - 1));
         pos = pos + e;
         chk_bit(rdf, pos == len + 1);
         if (pos == len + 1) begin
            chk_word(res, {4'h0, base + 12'h111 * 12'(len)});
            pos = 0;
            strobe(rc);
         end
      end
      // Injected split, three channels, fourth trigger wraps
      cfg.regular_split_enable = 1'b0;
      cfg.injected_split_enable = 1'b1;
      cfg.injected_sequence_length = 2'h2;
      for (int t = 0; t < 4; t++) begin
         n0 = nd;
         fire(1'b1, 7);
         settle(n0 + 1);
         chk_word(16'(lrk), 16'(t % 3));
         chk_bit(idf, t == 2);
         chk_bit(rdf, t == 2);
         chk_bit(iss, 1'b0);
         strobe(rc);
         strobe(ic);
      end
      // Single injected trigger preempts a slow regular scan
      cfg.injected_split_enable = 1'b0;
      cfg.injected_sequence_length = 2'h1;
      lat = 4'hc;
      n0 = nd;
      a0 = nab;
      fire(1'b0, 7);
      cyc(5);
      fire(1'b1, 7);
      cyc(3);
      fire(1'b0, 7);
      settle(n0 + len + 3 - pos);
      chk_word(16'(nab - a0), 16'h0001);
      chk_word(16'(nd - n0), 16'(len + 3 - pos));
      chk_bit(rdf, 1'b1);
      // Continuous run from a timer, then stop after two answers
      cfg.scan_enable = 1'b0;
      cfg.continuous_enable = 1'b1;
      cfg.regular_trigger_select = 3'h0;
      n0 = nd;
      fire(1'b0, 0);
      settle(n0 + 2);
      r0 = res;
      strobe(sp);
      cyc(1);
      chk_bit(stp, 1'b1);
      cyc(3);
      chk_bit(stp, 1'b0);
      chk_bit(rss, 1'b0);
      s0 = ns;
      cyc(30);
      chk_word(16'(ns - s0), 16'h0000);
      chk_word(res, r0);
      // Random window checks on the raw result
      cfg.continuous_enable = 1'b0;
      repeat (8) begin
         base = 12'($urandom);
         cfg.high_threshold = 12'($urandom);
         cfg.low_threshold = 12'($urandom);
         cfg.single_channel_guard = 1'($urandom);
         cfg.guard_channel = 5'($urandom_range(1));
         cfg.regular_guard_enable = 1'($urandom);
         cfg.injected_guard_enable = 1'($urandom);
         cfg.window_guard_irq_enable = 1'($urandom);
         cfg.regular_done_irq_enable = 1'($urandom);
         n0 = nd;
         fire(1'b0, 0);
         settle(n0 + 1);
         chk_bit(wgf, wd_exp(base));
         chk_bit(wgi, wd_exp(base) & cfg.window_guard_irq_enable);
         chk_bit(rdi, cfg.regular_done_irq_enable);
         strobe(wc);
         strobe(rc);
      end
      // Auto injection after a regular scan
      strobe(ic);
      cfg.scan_enable = 1'b1;
      cfg.auto_injection_enable = 1'b1;
      cfg.injected_trigger_enable = 1'b0;
      n0 = nd;
      fire(1'b0, 0);
      settle(n0 + len + 3);
      chk_word(16'(nd - n0), 16'(len + 3));
      chk_bit(idf, 1'b1);
      summarize();
   end
endmodule : adc_sequence_trigger_control_bench
`default_nettype wire
